// [dv/audio_filter_mix_config_regs_bench.sv]
// self-checking bench of the filter and mixer configuration bank
module audio_filter_mix_config_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import codec_cfg_pkg::*;
	logic        mclk_i;
	logic        rst_i;
	logic        power_down_n_i;
	logic        master_mode_i;
	logic        scl;
	logic        sda_host;
	wire logic   sda_wire;
	logic        sda_o;
	logic        sda_oe_n_o;
	logic        bit_clock_o;
	logic        bit_clock_oe_n_o;
	logic        frame_clock_o;
	logic        frame_clock_oe_n_o;
	filter_cfg_s filter_cfg_o;
	analog_cfg_s analog_cfg_o;
	logic [7:0]  e [17:35];
	int          fails;
	int          n_checks;
	// pull-up: low when either end pulls
	assign sda_wire = sda_host & (sda_oe_n_o | sda_o);
	codec_cfg_regs dut (.mclk_i, .rst_i, .power_down_n_i, .scl_i(scl), .sda_i(sda_wire), .sda_o, .sda_oe_n_o,
		.master_mode_i, .bit_clock_o, .bit_clock_oe_n_o, .frame_clock_o, .frame_clock_oe_n_o,
		.filter_cfg_o, .analog_cfg_o);
	cfg_bus_host host (.mclk_i, .sda_i(sda_wire), .scl_o(scl), .sda_o(sda_host));
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end
	function automatic logic [7:0] mask(input int i);
		case (i)
			17: return 8'h1c;
			19, 29: return 8'hbf;
			21, 25, 31, 33: return 8'h3f;
			35: return 8'h7f;
			default: return 8'hff;
		endcase
	endfunction
	// a disabled filter shows zero coefficients but keeps its type bit
	function automatic filter_cfg_s exp_f();
		logic [4:2] f;
		f = e[17][4:2];
		return {f[2], !f[2], e[19][7], {28{f[2]}} & {e[19][5:0], e[18], e[21][5:0], e[20]},
			f[3], !f[3], {46{f[3]}} & {e[23], e[22], e[25][5:0], e[24], e[27], e[26]},
			f[4], !f[4], e[29][7], {28{f[4]}} & {e[29][5:0], e[28], e[31][5:0], e[30]}};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_cfg();
		n_checks++;
		if (filter_cfg_o !== exp_f() || analog_cfg_o !== {e[32], e[33], e[34], e[35], e[33][1]}) begin
			fails++;
			$display("CHECK FAILED t=%0t config outputs differ", $time);
		end
	endtask
	task automatic rd_all();
		logic [7:0] d;
		for (int i = 17; i <= 35; i++) begin
			host.read_reg(i[7:0], d);
			chk(d, e[i]);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge mclk_i);
		fails++;
		test_done();
	end
	initial begin
		logic [7:0] d;
		logic       a;
		logic [7:0] q[$];
		int         n;
		rst_i = 1'b1;
		power_down_n_i = 1'b0;
		master_mode_i = 1'b0;
		repeat (20) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (8) @(posedge mclk_i);
		power_down_n_i <= 1'b1;
		repeat (8) @(posedge mclk_i);
		foreach (e[i]) e[i] = 8'h00;
		chk_cfg();
		rd_all();
		for (int i = 17; i <= 35; i++) q.push_back(8'hff);
		host.write_regs(DEV_ADDR, 8'h11, q, a);
		foreach (e[i]) e[i] = mask(i);
		rd_all();
		chk_cfg();
		q.delete();
		for (int i = 18; i <= 35; i++) begin
			q.push_back({~i[3:0], i[3:0]});
			e[i] = q[i-18] & mask(i);
		end
		host.write_regs(DEV_ADDR, 8'h12, q, a);
		rd_all();
		for (int f = 0; f < 8; f++) begin
			e[17] = {3'h0, f[2:0], 2'h0};
			q = {8'he3 | e[17]};
			host.write_regs(DEV_ADDR, 8'h11, q, a);
			host.read_reg(8'h11, d);
			chk(d, e[17]);
			chk_cfg();
		end
		host.write_regs(DEV_ADDR, 8'h24, q, a);
		chk({7'h0, a}, 8'h00);
		host.read_reg(8'h24, d);
		chk(d, 8'h00);
		host.write_regs(DEV_ADDR ^ 7'h01, 8'h20, q, a);
		chk({7'h0, a}, 8'h01);
		chk_cfg();
		chk({6'h0, bit_clock_oe_n_o, frame_clock_oe_n_o}, 8'h03);
		master_mode_i <= 1'b1;
		repeat (16) @(posedge mclk_i);
		chk({6'h0, bit_clock_oe_n_o, frame_clock_oe_n_o}, 8'h00);
		n = 0;
		repeat (64) begin
			a = bit_clock_o;
			@(posedge mclk_i);
			if (!a && bit_clock_o)
				n++;
		end
		chk(n[7:0], 8'h08);
		n = 0;
		repeat (512) begin
			a = frame_clock_o;
			@(posedge mclk_i);
			if (a !== frame_clock_o)
				n++;
		end
		chk(n[7:0], 8'h02);
		master_mode_i <= 1'b0;
		power_down_n_i <= 1'b0;
		repeat (8) @(posedge mclk_i);
		power_down_n_i <= 1'b1;
		repeat (8) @(posedge mclk_i);
		foreach (e[i]) e[i] = 8'h00;
		chk_cfg();
		chk({6'h0, bit_clock_oe_n_o, frame_clock_oe_n_o}, 8'h03);
		host.read_reg(8'h20, d);
		chk(d, 8'h00);
		test_done();
	end
endmodule

// [dv/cfg_bus_host.sv]
// serial control bus host model that reaches the configuration bank
module cfg_bus_host (
	// clock and wire level
	input  wire logic mclk_i,
	input  wire logic sda_i,
	// driven pins, one means released
	output logic      scl_o,
	output logic      sda_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import codec_cfg_pkg::*;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// eight clocks a bit: data moves mid-low, so read data has settled before the rise
	task automatic slot(input logic b, output logic r);
		scl_o <= 1'b0;
		repeat (2) @(posedge mclk_i);
		sda_o <= b;
		repeat (3) @(posedge mclk_i);
		scl_o <= 1'b1;
		repeat (3) @(posedge mclk_i);
		r = sda_i;
	endtask
	// data turns while the clock is high: 1 then 0 starts, 0 then 1 stops
	task automatic cond(input logic s0, input logic s1);
		logic r;
		slot(s0, r);
		sda_o <= s1;
		repeat (3) @(posedge mclk_i);
	endtask
	task automatic byte_io(input logic [7:0] tx, input logic ak, output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--) slot(tx[i], rx[i]);
		slot(ak, ack);
	endtask
	task automatic write_regs(input logic [6:0] dev, input logic [7:0] off, input logic [7:0] q[$], output logic ack);
		logic [7:0] rx;
		logic       a;
		cond(1'b1, 1'b0);
		byte_io({dev, 1'b0}, 1'b1, rx, ack);
		byte_io(off, 1'b1, rx, a);
		foreach (q[i]) byte_io(q[i], 1'b1, rx, a);
		cond(1'b0, 1'b1);
	endtask
	// pointer, repeated start, one byte refused so the device lets go
	task automatic read_reg(input logic [7:0] off, output logic [7:0] d);
		logic a;
		cond(1'b1, 1'b0);
		byte_io({DEV_ADDR, 1'b0}, 1'b1, d, a);
		byte_io(off, 1'b1, d, a);
		cond(1'b1, 1'b0);
		byte_io({DEV_ADDR, 1'b1}, 1'b1, d, a);
		byte_io(8'hff, 1'b1, d, a);
		cond(1'b0, 1'b1);
	endtask
endmodule

// [hdl/codec_cfg_pkg.sv]
// shared offsets, field layouts, timing counts and carriers of the codec filter and mixer bank
package codec_cfg_pkg;
	// register offsets
	localparam logic [7:0] REG_FILTER_SELECT      = 8'h11;
	localparam logic [7:0] REG_EMPH_COEF_A_LOW    = 8'h12;
	localparam logic [7:0] REG_EMPH_COEF_A_HI_SEL = 8'h13;
	localparam logic [7:0] REG_EMPH_COEF_B_LOW    = 8'h14;
	localparam logic [7:0] REG_EMPH_COEF_B_HIGH   = 8'h15;
	localparam logic [7:0] REG_EQ_COEF_A_LOW      = 8'h16;
	localparam logic [7:0] REG_EQ_COEF_A_HIGH     = 8'h17;
	localparam logic [7:0] REG_EQ_COEF_B_LOW      = 8'h18;
	localparam logic [7:0] REG_EQ_COEF_B_HIGH     = 8'h19;
	localparam logic [7:0] REG_EQ_COEF_C_LOW      = 8'h1a;
	localparam logic [7:0] REG_EQ_COEF_C_HIGH     = 8'h1b;
	localparam logic [7:0] REG_WIND_COEF_A_LOW    = 8'h1c;
	localparam logic [7:0] REG_WIND_COEF_A_HI_SEL = 8'h1d;
	localparam logic [7:0] REG_WIND_COEF_B_LOW    = 8'h1e;
	localparam logic [7:0] REG_WIND_COEF_B_HIGH   = 8'h1f;
	localparam logic [7:0] REG_MIC_MIXER_POWER    = 8'h20;
	localparam logic [7:0] REG_ANALOG_PATH_MODE   = 8'h21;
	localparam logic [7:0] REG_LINE_OUT_MIX       = 8'h22;
	localparam logic [7:0] REG_HEADPHONE_MIX      = 8'h23;
	localparam int         NUM_REGS               = 19;
	// reset value shared by every offset; writable bits, one entry per offset from 11h upward
	localparam logic [7:0] REG_RESET_VAL          = 8'h00;
	localparam logic [NUM_REGS-1:0][7:0] WRITE_MASK = {
		8'h7f, 8'hff, 8'h3f, 8'hff, 8'h3f, 8'hff, 8'hbf, 8'hff, 8'hff, 8'hff,
		8'h3f, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hbf, 8'hff, 8'h1c};
	// field positions
	localparam int         FSEL_EMPH_BIT          = 2;
	localparam int         FSEL_EQ_BIT            = 3;
	localparam int         FSEL_WIND_BIT          = 4;
	localparam int         TYPE_SEL_BIT           = 7;
	localparam int         COEF_HI_W              = 6;
	// serial bus
	localparam logic [6:0] DEV_ADDR               = 7'h12;
	localparam logic [3:0] BYTE_BITS              = 4'h8;
	// master clock divider: bit clock is mclk/8, 32 bit clocks per frame half
	localparam logic [2:0] BCLK_DIV_LAST          = 3'h3;
	localparam logic [4:0] HALF_FRAME_LAST        = 5'h1f;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_ADDR      = 4'h1,
		ST_ADDR_ACK  = 4'h3,
		ST_REG       = 4'h2,
		ST_REG_ACK   = 4'h6,
		ST_WDATA     = 4'h7,
		ST_WDATA_ACK = 4'h5,
		ST_RDATA     = 4'h4,
		ST_RDATA_ACK = 4'hc
	} bus_state_e;

	typedef struct packed {
		logic        emph_run;
		logic        emph_mute;
		logic        emph_lowpass;
		logic [13:0] emph_coef_a;
		logic [13:0] emph_coef_b;
		logic        eq_run;
		logic        eq_bypass;
		logic [15:0] equaliser_coef_a;
		logic [13:0] equaliser_coef_b;
		logic [15:0] equaliser_coef_c;
		logic        wind_run;
		logic        wind_bypass;
		logic        wind_lowpass;
		logic [13:0] wind_coef_a;
		logic [13:0] wind_coef_b;
	} filter_cfg_s;

	typedef struct packed {
		logic mixer_in4_right_power;
		logic mixer_in4_left_power;
		logic mixer_in3_right_power;
		logic mixer_in3_left_power;
		logic mixer_in2_right_power;
		logic mixer_in2_left_power;
		logic mic_amp_right_power;
		logic mic_amp_left_power;
	} power_s;

	typedef struct packed {
		logic [1:0] zero;
		logic       right_in3_from_mic_amp;
		logic       left_in3_from_mic_amp;
		logic       in4_differential;
		logic       mono_record;
		logic       stereo_in3_mixing;
		logic       line_out_differential;
	} mode_s;

	typedef struct packed {
		logic lineout_mono_dac_mix;
		logic lineout_mono_in3_mix;
		logic lineout_right_in4_switch;
		logic lineout_left_in4_switch;
		logic lineout_right_in3_switch;
		logic lineout_left_in3_switch;
		logic lineout_right_in2_switch;
		logic lineout_left_in2_switch;
	} lineout_s;

	typedef struct packed {
		logic zero;
		logic hp_mono_in3_mix;
		logic hp_right_in4_switch;
		logic hp_left_in4_switch;
		logic hp_right_in3_switch;
		logic hp_left_in3_switch;
		logic hp_right_in2_switch;
		logic hp_left_in2_switch;
	} hp_s;

	typedef struct packed {
		power_s   power;
		mode_s    mode;
		lineout_s lineout;
		hp_s      hp;
		logic     pll_inhibit;
	} analog_cfg_s;
endpackage

// [hdl/codec_cfg_regs.sv]
// filter, power and mixer configuration bank of the codec behind the control serial bus
// Function
// - emphasis enable set applies its coefficients; clear turns the emphasis filter off, muted.
// - equaliser enable set uses A, B, C coefficients; clear passes at unity gain.
// - wind enable set applies its coefficients; clear passes the signal at unity gain.
// - two 14-bit emphasis coefficients, zero default, low byte 12h/14h, high bits 13h/15h.
// - bit 7 of 13h picks emphasis type: 0 high-pass, 1 low-pass.
// - equaliser A 16-bit at 16h/17h, B 14-bit at 18h/19h, C 16-bit at 1Ah/1Bh.
// - two 14-bit wind coefficients, zero default, at 1Ch/1Dh and 1Eh/1Fh.
// - bit 7 of 1Dh picks wind filter type: 0 high-pass, 1 low-pass.
// - each bit of 20h powers up a mic amplifier or input mixer when 1.
// - bit 0 of 21h picks single-ended stereo or differential mono line output.
// - bit 1 of 21h picks mono or stereo input-3 mixing; stereo forbids the PLL.
// - 21h bit 2 makes recording mono; bit 3 makes input 4 differential.
// - 21h bits 4 and 5 take input-3 path from the pin or mic amplifier.
// - 22h bits 0 to 5 close switches from inputs 2, 3, 4 to line output.
// - 22h bit 6 mixes input-3 path mono, bit 7 mixes the DAC mono, to line output.
// - 23h bits 0 to 5 close switches from inputs 2, 3, 4 to headphone output.
// - 23h bit 6 mixes input-3 path mono to headphones; bit 7 reserved zero.
// - frame and bit clock pins stay undriven until master mode is selected.
// - filter-select register holds emphasis, equaliser and wind enables in bits 2, 3, 4.
module codec_cfg_regs (
	// clock and reset
	input  wire logic                        mclk_i,
	input  wire logic                        rst_i,
	// power-down pin
	input  wire logic                        power_down_n_i,
	// control serial bus, open drain
	input  wire logic                        scl_i,
	input  wire logic                        sda_i,
	output logic                             sda_o,
	output logic                             sda_oe_n_o,
	// audio clock pins
	input  wire logic                        master_mode_i,
	output logic                             bit_clock_o,
	output logic                             bit_clock_oe_n_o,
	output logic                             frame_clock_o,
	output logic                             frame_clock_oe_n_o,
	// configuration to the datapath
	output codec_cfg_pkg::filter_cfg_s       filter_cfg_o,
	output codec_cfg_pkg::analog_cfg_s       analog_cfg_o
);
	import codec_cfg_pkg::*;

	// pin synchronisers; only the second stage and the edge history are looked at
	logic [1:0]                scl_sq, sda_sq, pdn_sq;
	logic                      scl_prev_q, sda_prev_q;
	logic                      scl_s, sda_s, pdn_s;
	logic                      scl_rise, scl_fall, start, stop;

	// bus engine
	bus_state_e                st_q, st_d;
	logic [3:0]                cnt_q, cnt_d;
	logic [7:0]                sh_q, sh_d;
	logic [7:0]                ptr_q, ptr_d;
	logic                      rw_q, rw_d;
	logic                      drv_q, drv_d;
	logic                      ack_q, ack_d;
	logic                      wr_en;
	logic [7:0]                rd_byte;

	// register file
	logic [NUM_REGS-1:0][7:0]  reg_q, reg_d;
	logic [NUM_REGS-1:0]       wr_sel;

	// decoded configuration
	filter_cfg_s               filt_q, filt_d;
	analog_cfg_s               ana_q, ana_d;
	logic [13:0]               emph_a_raw, emph_b_raw, eq_b_raw, wind_a_raw, wind_b_raw;
	logic [15:0]               eq_a_raw, eq_c_raw;
	logic                      emph_sel_raw, wind_sel_raw;
	logic                      emph_on, eq_on, wind_on;

	// unmapped offsets read as zero
	function automatic logic [7:0] rd_reg(input logic [7:0] a);
		logic [7:0] idx;
		idx = a - REG_FILTER_SELECT;
		if (a >= REG_FILTER_SELECT && a <= REG_HEADPHONE_MIX) begin
			return reg_q[idx[4:0]];
		end
		return 8'h00;
	endfunction

	function automatic logic [13:0] coef14(input logic [7:0] lo);
		logic [7:0] hi;
		hi = rd_reg(lo + 8'h01);
		return {hi[COEF_HI_W-1:0], rd_reg(lo)};
	endfunction

	function automatic logic [15:0] coef16(input logic [7:0] lo);
		return {rd_reg(lo + 8'h01), rd_reg(lo)};
	endfunction

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			scl_sq     <= 2'h3;
			sda_sq     <= 2'h3;
			pdn_sq     <= 2'h0;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_sq     <= {scl_sq[0], scl_i};
			sda_sq     <= {sda_sq[0], sda_i};
			pdn_sq     <= {pdn_sq[0], power_down_n_i};
			scl_prev_q <= scl_sq[1];
			sda_prev_q <= sda_sq[1];
		end
	end

	assign scl_s    = scl_sq[1];
	assign sda_s    = sda_sq[1];
	// a short power-down pulse may be missed; the system keeps it long enough
	assign pdn_s    = pdn_sq[1];
	assign scl_rise = scl_s && !scl_prev_q;
	assign scl_fall = !scl_s && scl_prev_q;
	assign start    = scl_s && scl_prev_q && sda_prev_q && !sda_s;
	assign stop     = scl_s && scl_prev_q && !sda_prev_q && sda_s;

	// bus engine: address, register pointer, data with auto increment
	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		sh_d    = sh_q;
		ptr_d   = ptr_q;
		rw_d    = rw_q;
		drv_d   = drv_q;
		ack_d   = ack_q;
		wr_en   = 1'b0;
		rd_byte = rd_reg(ptr_q);
		if (!pdn_s) begin
			st_d  = ST_IDLE;
			cnt_d = 4'h0;
			sh_d  = 8'h00;
			ptr_d = 8'h00;
			rw_d  = 1'b0;
			drv_d = 1'b0;
			ack_d = 1'b0;
		end else if (start) begin
			st_d  = ST_ADDR;
			cnt_d = 4'h0;
			drv_d = 1'b0;
		end else if (stop) begin
			st_d  = ST_IDLE;
			drv_d = 1'b0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					drv_d = 1'b0;
				end
				ST_ADDR, ST_REG, ST_WDATA: begin
					if (scl_rise) begin
						sh_d  = {sh_q[6:0], sda_s};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == BYTE_BITS) begin
						cnt_d = 4'h0;
						case (st_q)
							ST_ADDR: begin
								if (sh_q[7:1] == DEV_ADDR) begin
									st_d  = ST_ADDR_ACK;
									rw_d  = sh_q[0];
									drv_d = 1'b1;
								end else begin
									st_d = ST_IDLE;
								end
							end
							ST_REG: begin
								st_d  = ST_REG_ACK;
								ptr_d = sh_q;
								drv_d = 1'b1;
							end
							default: begin
								st_d  = ST_WDATA_ACK;
								wr_en = 1'b1;
								ptr_d = ptr_q + 8'h01;
								drv_d = 1'b1;
							end
						endcase
					end
				end
				ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK: begin
					if (scl_fall) begin
						cnt_d = 4'h0;
						drv_d = 1'b0;
						if (st_q == ST_ADDR_ACK && rw_q) begin
							st_d  = ST_RDATA;
							sh_d  = rd_byte;
							ptr_d = ptr_q + 8'h01;
							drv_d = !rd_byte[7];
						end else if (st_q == ST_ADDR_ACK) begin
							st_d = ST_REG;
						end else begin
							st_d = ST_WDATA;
						end
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						cnt_d = cnt_q + 4'h1;
						if (cnt_q == BYTE_BITS - 4'h1) begin
							st_d  = ST_RDATA_ACK;
							drv_d = 1'b0;
						end else begin
							sh_d  = {sh_q[6:0], 1'b0};
							drv_d = !sh_q[6];
						end
					end
				end
				ST_RDATA_ACK: begin
					if (scl_rise) begin
						ack_d = !sda_s;
					end else if (scl_fall) begin
						cnt_d = 4'h0;
						if (ack_q) begin
							st_d  = ST_RDATA;
							sh_d  = rd_byte;
							ptr_d = ptr_q + 8'h01;
							drv_d = !rd_byte[7];
						end else begin
							st_d = ST_IDLE;
						end
					end
				end
				default: begin
					st_d  = ST_IDLE;
					drv_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q  <= ST_IDLE;
			cnt_q <= 4'h0;
			sh_q  <= 8'h00;
			ptr_q <= 8'h00;
			rw_q  <= 1'b0;
			drv_q <= 1'b0;
			ack_q <= 1'b0;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
			sh_q  <= sh_d;
			ptr_q <= ptr_d;
			rw_q  <= rw_d;
			drv_q <= drv_d;
			ack_q <= ack_d;
		end
	end

	// open drain: only ever pulls low
	assign sda_o      = 1'b0;
	assign sda_oe_n_o = !drv_q;

	// register file, one entry per offset; writes outside the map are dropped
	for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
		assign wr_sel[i] = wr_en && (ptr_q - REG_FILTER_SELECT == 8'(i)) && (ptr_q >= REG_FILTER_SELECT);
		always_comb begin
			reg_d[i] = reg_q[i];
			if (!pdn_s) begin
				reg_d[i] = REG_RESET_VAL;
			end else if (wr_sel[i]) begin
				reg_d[i] = sh_q & WRITE_MASK[i];
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_q <= '0;
		end else begin
			reg_q <= reg_d;
		end
	end

	// decode; disabled filters see zero coefficients so stale values never leak into the arithmetic
	always_comb begin
		emph_on      = reg_q[0][FSEL_EMPH_BIT];
		eq_on        = reg_q[0][FSEL_EQ_BIT];
		wind_on      = reg_q[0][FSEL_WIND_BIT];
		emph_a_raw   = coef14(REG_EMPH_COEF_A_LOW);
		emph_b_raw   = coef14(REG_EMPH_COEF_B_LOW);
		eq_a_raw     = coef16(REG_EQ_COEF_A_LOW);
		eq_b_raw     = coef14(REG_EQ_COEF_B_LOW);
		eq_c_raw     = coef16(REG_EQ_COEF_C_LOW);
		wind_a_raw   = coef14(REG_WIND_COEF_A_LOW);
		wind_b_raw   = coef14(REG_WIND_COEF_B_LOW);
		emph_sel_raw = rd_reg(REG_EMPH_COEF_A_HI_SEL) >> TYPE_SEL_BIT == 8'h01;
		wind_sel_raw = rd_reg(REG_WIND_COEF_A_HI_SEL) >> TYPE_SEL_BIT == 8'h01;
		filt_d.emph_run         = emph_on;
		filt_d.emph_mute        = !emph_on;
		filt_d.emph_lowpass     = emph_sel_raw;
		filt_d.emph_coef_a      = emph_on ? emph_a_raw : 14'h0000;
		filt_d.emph_coef_b      = emph_on ? emph_b_raw : 14'h0000;
		filt_d.eq_run           = eq_on;
		filt_d.eq_bypass        = !eq_on;
		filt_d.equaliser_coef_a = eq_on ? eq_a_raw : 16'h0000;
		filt_d.equaliser_coef_b = eq_on ? eq_b_raw : 14'h0000;
		filt_d.equaliser_coef_c = eq_on ? eq_c_raw : 16'h0000;
		filt_d.wind_run         = wind_on;
		filt_d.wind_bypass      = !wind_on;
		filt_d.wind_lowpass     = wind_sel_raw;
		filt_d.wind_coef_a      = wind_on ? wind_a_raw : 14'h0000;
		filt_d.wind_coef_b      = wind_on ? wind_b_raw : 14'h0000;
		ana_d.power       = power_s'(rd_reg(REG_MIC_MIXER_POWER));
		// mode carries line output form, in3 mixing mode, mono record, in4 type, in3 source
		ana_d.mode        = mode_s'(rd_reg(REG_ANALOG_PATH_MODE));
		ana_d.lineout     = lineout_s'(rd_reg(REG_LINE_OUT_MIX));
		ana_d.hp          = hp_s'(rd_reg(REG_HEADPHONE_MIX));
		// input-3 right pin doubles as the loop filter pin, so stereo in3 locks out the PLL
		ana_d.pll_inhibit = ana_d.mode.stereo_in3_mixing;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			// disabled filters leave reset muted or bypassed, as their enables read zero
			filt_q <= '{emph_mute: 1'b1, eq_bypass: 1'b1, wind_bypass: 1'b1, default: '0};
			ana_q  <= '0;
		end else begin
			filt_q <= filt_d;
			ana_q  <= ana_d;
		end
	end

	assign filter_cfg_o = filt_q;
	assign analog_cfg_o = ana_q;

	codec_clk_master u_clk_master (
		.mclk_i             (mclk_i),
		.rst_i              (rst_i),
		.master_i           (master_mode_i && pdn_s),
		.bit_clock_o        (bit_clock_o),
		.bit_clock_oe_n_o   (bit_clock_oe_n_o),
		.frame_clock_o      (frame_clock_o),
		.frame_clock_oe_n_o (frame_clock_oe_n_o)
	);

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	a_emph_mute: assert property (1'b1 |=> filter_cfg_o.emph_mute == !$past(reg_q[0][FSEL_EMPH_BIT]))
		else $error("emphasis mute does not follow its enable");
	a_eq_through: assert property (!eq_on |=> filter_cfg_o.eq_bypass && filter_cfg_o.equaliser_coef_a == 16'h0000)
		else $error("equaliser not bypassed while disabled");
	a_wind_through: assert property (!wind_on |=> filter_cfg_o.wind_bypass && filter_cfg_o.wind_coef_b == 14'h0000)
		else $error("wind filter not bypassed while disabled");
	a_emph_coef: assert property (emph_on |=> filter_cfg_o.emph_coef_a == $past(emph_a_raw) && filter_cfg_o.emph_coef_b == $past(emph_b_raw))
		else $error("emphasis coefficient mismatch");
	a_emph_type: assert property (1'b1 |=> filter_cfg_o.emph_lowpass == $past(reg_q[2][TYPE_SEL_BIT]))
		else $error("emphasis type select mismatch");
	a_eq_coef: assert property (eq_on |=> filter_cfg_o.equaliser_coef_c == $past(eq_c_raw) && filter_cfg_o.equaliser_coef_b == $past(eq_b_raw))
		else $error("equaliser coefficient mismatch");
	a_wind_coef: assert property (wind_on |=> filter_cfg_o.wind_coef_a == $past(wind_a_raw))
		else $error("wind coefficient mismatch");
	a_wind_type: assert property (1'b1 |=> filter_cfg_o.wind_lowpass == $past(reg_q[12][TYPE_SEL_BIT]))
		else $error("wind type select mismatch");
	a_power_map: assert property (1'b1 |=> analog_cfg_o.power == $past(reg_q[15]))
		else $error("power bits do not follow register");
	a_pll_lock: assert property (analog_cfg_o.pll_inhibit == analog_cfg_o.mode.stereo_in3_mixing)
		else $error("pll inhibit does not follow stereo in3 mixing");
	a_rsvd_zero: assert property (reg_q[18][7] == 1'b0 && reg_q[2][6] == 1'b0 && reg_q[16][7:6] == 2'h0)
		else $error("reserved bit set");
	a_pdn_clear: assert property (!pdn_s |=> reg_q == '0 ##1 analog_cfg_o == '0)
		else $error("power-down did not restore defaults");
	a_addr_ack: assert property (st_q == ST_ADDR_ACK |-> !sda_oe_n_o)
		else $error("address acknowledge not driven");
endmodule

// [hdl/codec_clk_master.sv]
// master-mode bit and frame clock divider that releases its pins in slave mode
module codec_clk_master (
	// clock and reset
	input  wire logic mclk_i,
	input  wire logic rst_i,
	// control
	input  wire logic master_i,
	// audio clock pins
	output logic      bit_clock_o,
	output logic      bit_clock_oe_n_o,
	output logic      frame_clock_o,
	output logic      frame_clock_oe_n_o
);
	import codec_cfg_pkg::*;

	logic [2:0] div_q, div_d;
	logic [4:0] bits_q, bits_d;
	logic       bclk_q, bclk_d;
	logic       fclk_q, fclk_d;
	logic       oe_n_q, oe_n_d;

	always_comb begin
		div_d  = div_q;
		bits_d = bits_q;
		bclk_d = bclk_q;
		fclk_d = fclk_q;
		oe_n_d = !master_i;
		if (!master_i) begin
			div_d  = 3'h0;
			bits_d = 5'h00;
			bclk_d = 1'b0;
			fclk_d = 1'b0;
		end else if (div_q == BCLK_DIV_LAST) begin
			div_d  = 3'h0;
			bclk_d = !bclk_q;
			// frame clock moves on the bit clock's falling edge so it is stable at the rising one
			if (bclk_q) begin
				bits_d = bits_q + 5'h01;
				if (bits_q == HALF_FRAME_LAST) begin
					fclk_d = !fclk_q;
				end
			end
		end else begin
			div_d = div_q + 3'h1;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			div_q  <= 3'h0;
			bits_q <= 5'h00;
			bclk_q <= 1'b0;
			fclk_q <= 1'b0;
			oe_n_q <= 1'b1;
		end else begin
			div_q  <= div_d;
			bits_q <= bits_d;
			bclk_q <= bclk_d;
			fclk_q <= fclk_d;
			oe_n_q <= oe_n_d;
		end
	end

	assign bit_clock_o        = bclk_q;
	assign frame_clock_o      = fclk_q;
	assign bit_clock_oe_n_o   = oe_n_q;
	assign frame_clock_oe_n_o = oe_n_q;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	a_pins_released: assert property (!master_i |=> bit_clock_oe_n_o && frame_clock_oe_n_o && !bit_clock_o)
		else $error("audio clock pins driven outside master mode");
	a_pins_driven: assert property (master_i ##1 master_i |-> !bit_clock_oe_n_o && !frame_clock_oe_n_o)
		else $error("audio clock pins not driven in master mode");
endmodule
